//--- frame_tx_pkg.sv
package frame_tx_pkg;

  // register byte offsets (chosen map, one aligned word each)
  localparam logic [7:0] OFF_DATA    = 8'h00;  // serial_data_register
  localparam logic [7:0] OFF_STAT_A  = 8'h04;  // control_status_a
  localparam logic [7:0] OFF_CTRL_B  = 8'h08;  // control_status_b
  localparam logic [7:0] OFF_CTRL_C  = 8'h0C;  // control_status_c / baud_divisor_high
  localparam logic [7:0] OFF_BAUD_LO = 8'h10;  // baud_divisor low byte

  // control_status_a fields
  localparam int A_DBL_POS   = 1;  // double_speed_bit
  localparam int A_FE_POS    = 4;  // frame_error_flag
  localparam int A_EMPTY_POS = 5;  // data_reg_empty_flag
  localparam int A_TXC_POS   = 6;  // tx_complete_flag
  localparam int A_RXC_POS   = 7;  // rx_complete_flag

  // control_status_b fields
  localparam int B_NINTH_POS = 0;  // tx_ninth_bit
  localparam int B_SIZE2_POS = 2;  // char_size_field bit 2
  localparam int B_TX_ENABLE_BIT_POS  = 3;  // tx_enable_bit

  // control_status_c fields
  localparam int C_POL_POS   = 0;  // clock_polarity_bit
  localparam int C_SIZE_LO   = 1;  // char_size_field bits 1:0
  localparam int C_STOP_POS  = 3;  // stop_bits_select
  localparam int C_PAR_LO    = 4;  // parity_mode_field
  localparam int C_SYNC_POS  = 6;  // sync_mode_select
  localparam int C_SEL_POS   = 7;  // reg_select_bit

  // reset values
  localparam logic [7:0]  RST_CTRL_C = 8'h06;  // 8 data bits, no parity, 1 stop
  localparam logic [11:0] RST_BAUD   = 12'h000;

  // character size code for nine-bit characters
  localparam logic [2:0] SIZE_NINE = 3'h7;

  // transmit sequencer states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_START  = 3'b001,
    ST_DATA   = 3'b010,
    ST_PARITY = 3'b011,
    ST_STOP1  = 3'b100,
    ST_STOP2  = 3'b101
  } tx_state_t;

  // frame format carried as one bundle
  typedef struct packed {
    logic [2:0] size;    // char_size_field
    logic [1:0] parity;  // parity_mode_field
    logic       stop2;   // stop_bits_select
  } frame_fmt_t;

  // clocking mode bundle
  typedef struct packed {
    logic sync;    // sync_mode_select
    logic master;  // pin direction: internal clock
    logic pol;     // clock_polarity_bit
    logic dbl;     // double_speed_bit
  } clk_mode_t;

endpackage

//--- frame_tx_clkgen.sv
`timescale 1ns/100ps
// bit-rate enables: baud counter, async/sync dividers, external clock edges
module frame_tx_clkgen
  import frame_tx_pkg::*;
(
  // system
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // setup
  input  wire clk_mode_t   mode,
  input  wire logic [11:0] divisor,
  input  wire logic        reload,
  // external transfer clock pin
  input  wire logic        xck_in,
  // results
  output logic             shift_en,
  output logic             xck_out
);

  logic [11:0] count;     // baud down-counter
  logic [3:0]  sub;       // divide by 16, 8 or 2
  logic        xs1;       // first sync stage, read only by xs2
  logic        xs2;       // synchronised pin
  logic        xs3;       // previous synchronised level
  logic        int_tick;  // baud generator zero
  logic [3:0]  sub_max;   // last count of the divider
  logic        int_edge;  // internal divider wrap
  logic        ext_rise;  // pin rising edge
  logic        ext_fall;  // pin falling edge
  logic        change_rise; // data changes on rising edge when polarity clear

  assign int_tick    = (count == 12'h000);
  assign sub_max     = mode.sync ? 4'h1 : (mode.dbl ? 4'h7 : 4'hF);
  assign int_edge    = int_tick && (sub == sub_max);
  assign ext_rise    = xs2 && !xs3;
  assign ext_fall    = !xs2 && xs3;
  assign change_rise = !mode.pol;
  // slave: data changes on the chosen pin edge; master/async: internal divider
  assign shift_en = (mode.sync && !mode.master) ?
                    (change_rise ? ext_rise : ext_fall) : int_edge;

  // baud counter reloads on zero or on a write of the low byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 12'h000;
    end else if (reload || int_tick) begin
      count <= divisor;
    end else begin
      count <= count - 12'h001;
    end
  end

  // sub-divider; master clock toggles each half bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sub <= 4'h0;
      xck_out <= 1'b0;
    end else if (int_tick) begin
      sub <= (sub == sub_max) ? 4'h0 : sub + 4'h1;
      // output edge at wrap changes data, mid-period edge samples
      xck_out <= (sub == sub_max) ? change_rise : !change_rise;
    end
  end

  // two-flop synchroniser plus edge history
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xs1 <= 1'b0;
      xs2 <= 1'b0;
      xs3 <= 1'b0;
    end else begin
      xs1 <= xck_in;
      xs2 <= xs1;
      xs3 <= xs2;
    end
  end

  a_slave_edge: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode.sync && !mode.master && !mode.pol && shift_en) |-> (xs2 && !xs3))
    else $error("slave shift not on rising pin edge");

endmodule

//--- frame_tx_core.sv
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
// Functional notes
// - sync mode: pin is clock in or out
// - polarity picks change and sample edges
// - all thirty frame formats supported
// - start bit, then data LSB first
// - parity after data, before stop
// - back-to-back frames or idle line
// - start low, stop high, idle high
// - one shared format; host avoids midframe changes
// - size, parity and stop fields
// - receiver checks only first stop
// - parity is xor, inverted for odd
// - control C write needs select bit
// - enable hands pins to transmitter
// - buffer loads shifter when idle/after stop
// - shifter sends at selected bit rate
// - unused high data bits ignored
// - empty flag tracks transmit buffer
// - complete flag set at end, write-one clear
// - disable waits until all data sent
module frame_tx_core
  import frame_tx_pkg::*;
(
  // ahb-lite slave
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // serial line
  output logic             txd_out,
  output logic             txd_oe,
  // transfer clock pin
  input  wire logic        xck_in,
  output logic             xck_out,
  output logic             xck_oe,
  // receiver-side hooks
  input  wire logic        rx_stop1,
  input  wire logic        rx_stop_valid,
  input  wire logic        rx_done
);

  // bus address phase capture
  logic       wr_pend;     // write data phase pending
  logic [7:0] wr_addr;     // its address
  logic       ap_valid;    // valid transfer this cycle
  assign ap_valid  = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;  // zero wait states
  assign hresp     = 1'b0;  // always okay
  // control state
  logic        tx_enable_bit;       // tx_enable_bit as written
  logic        ninth;      // tx_ninth_bit
  logic        size2;      // char_size_field bit 2
  logic        master;     // clock pin direction, master when set
  logic [7:0]  ctrl_c;     // control_status_c
  logic [11:0] baud;       // baud_divisor
  logic        dbl;        // double_speed_bit
  logic        tx_active;  // transmitter owns the pin
  // flags
  logic        empty;      // data_reg_empty_flag
  logic        tx_complete_flag;        // tx_complete_flag
  logic        fe;         // frame_error_flag
  logic        rx_complete_flag;        // rx_complete_flag
  // buffer and shifter
  logic [8:0]  buf_data;   // transmit buffer
  logic [8:0]  shreg;      // shift register
  logic [3:0]  bit_cnt;    // data bits sent
  logic        par_bit;    // latched parity
  tx_state_t   state;
  tx_state_t   next_state;
  // decoded writes
  logic w_data;
  logic w_a;
  logic w_b;
  logic w_c;
  logic w_c_sel;
  logic w_baud_lo;
  assign w_data    = wr_pend && (wr_addr == OFF_DATA);
  assign w_a       = wr_pend && (wr_addr == OFF_STAT_A);
  assign w_b       = wr_pend && (wr_addr == OFF_CTRL_B);
  assign w_c       = wr_pend && (wr_addr == OFF_CTRL_C);
  assign w_c_sel   = w_c && hwdata[C_SEL_POS];
  assign w_baud_lo = wr_pend && (wr_addr == OFF_BAUD_LO);
  // format and mode bundles
  frame_fmt_t fmt;
  clk_mode_t  mode;
  assign fmt.size   = {size2, ctrl_c[C_SIZE_LO+1:C_SIZE_LO]};
  assign fmt.parity = ctrl_c[C_PAR_LO+1:C_PAR_LO];
  assign fmt.stop2  = ctrl_c[C_STOP_POS];
  assign mode.sync   = ctrl_c[C_SYNC_POS];
  assign mode.master = master;
  assign mode.pol    = ctrl_c[C_POL_POS];
  assign mode.dbl    = dbl;

  // data bits per size code: 5..8, code 7 is nine
  function automatic logic [3:0] data_bits(input logic [2:0] sz);
    logic [3:0] n;
    n = 4'h8;
    case (sz)
      3'h0: n = 4'h5;
      3'h1: n = 4'h6;
      3'h2: n = 4'h7;
      3'h3: n = 4'h8;
      SIZE_NINE: n = 4'h9;
      default: n = 4'h8;  // reserved codes behave as eight bits
    endcase
    return n;
  endfunction

  // mask unused high data bits and xor them
  function automatic logic calc_parity(input logic [8:0] d, input logic [3:0] n,
                                       input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(n)) begin
        p = p ^ d[i];
      end
    end
    return p;
  endfunction

  logic [3:0] nbits;
  logic       shift_en;
  logic       par_on;
  logic       frame_end;   // last stop bit finishing
  logic       load;        // buffer moves into shifter
  assign nbits  = data_bits(fmt.size);
  assign par_on = fmt.parity[1];
  assign frame_end = shift_en && ((state == ST_STOP2) || (state == ST_STOP1 && !fmt.stop2));
  // load on a bit boundary so the start bit is whole; pending disable still sends
  assign load = !empty && (tx_enable_bit || tx_active) &&
                ((state == ST_IDLE && shift_en) || frame_end);
  // bit-rate generator
  frame_tx_clkgen u_frame_tx_clkgen (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .mode     (mode),
    .divisor  (baud),
    .reload   (w_baud_lo),
    .xck_in   (xck_in),
    .shift_en (shift_en),
    .xck_out  (xck_out)
  );
  // pin ownership and clock direction
  assign txd_oe = tx_active;
  assign xck_oe = tx_active && mode.sync && master;
  // next state of the sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:   next_state = ST_IDLE;
      ST_START:  if (shift_en) next_state = ST_DATA;
      ST_DATA:   if (shift_en && bit_cnt == nbits - 4'h1)
                   next_state = par_on ? ST_PARITY : ST_STOP1;
      ST_PARITY: if (shift_en) next_state = ST_STOP1;
      ST_STOP1:  if (shift_en) next_state = fmt.stop2 ? ST_STOP2 : ST_IDLE;
      ST_STOP2:  if (shift_en) next_state = ST_IDLE;
      default:   next_state = ST_IDLE;
    endcase
    if (load) begin
      next_state = ST_START;
    end
  end

  // sequencer and shifter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state   <= ST_IDLE;
      shreg   <= 9'h000;
      bit_cnt <= 4'h0;
      par_bit <= 1'b0;
    end else begin
      state <= next_state;
      if (load) begin
        shreg   <= buf_data;
        bit_cnt <= 4'h0;
        par_bit <= calc_parity(buf_data, nbits, fmt.parity[0]);
      end else if (shift_en && state == ST_DATA) begin
        shreg   <= {1'b0, shreg[8:1]};
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end

  // serial output: start low, stop and idle high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txd_out <= 1'b1;
    end else begin
      case (next_state)
        ST_START:  txd_out <= 1'b0;
        ST_DATA:   txd_out <= (state == ST_DATA && shift_en) ? shreg[1] : shreg[0];
        ST_PARITY: txd_out <= par_bit;
        default:   txd_out <= 1'b1;
      endcase
    end
  end
  // transmit buffer, empty flag: write clears, load sets; write wins race
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buf_data <= 9'h000;
      empty    <= 1'b1;
    end else if (w_data) begin
      buf_data <= {ninth && (fmt.size == SIZE_NINE), hwdata[7:0]};
      empty    <= 1'b0;
    end else if (load) begin
      empty <= 1'b1;
    end
  end
  // complete flag: set beats write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_complete_flag <= 1'b0;
    end else if (frame_end && empty && !w_data) begin
      tx_complete_flag <= 1'b1;
    end else if (w_a && hwdata[A_TXC_POS]) begin
      tx_complete_flag <= 1'b0;
    end
  end
  // receiver status: first stop only decides frame error
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fe  <= 1'b0;
      rx_complete_flag <= 1'b0;
    end else begin
      if (rx_stop_valid) fe <= !rx_stop1;
      if (rx_done) rx_complete_flag <= 1'b1;
      else if (w_a && hwdata[A_RXC_POS]) rx_complete_flag <= 1'b0;
    end
  end
  // pin release only after everything is sent
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_active <= 1'b0;
    end else if (tx_enable_bit) begin
      tx_active <= 1'b1;
    end else if (state == ST_IDLE && empty) begin
      tx_active <= 1'b0;
    end
  end

  // register writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      tx_enable_bit    <= 1'b0;
      ninth   <= 1'b0;
      size2   <= 1'b0;
      master  <= 1'b0;
      ctrl_c  <= RST_CTRL_C;
      baud    <= RST_BAUD;
      dbl     <= 1'b0;
    end else begin
      wr_pend <= ap_valid && hwrite;
      wr_addr <= haddr;
      if (w_a) dbl <= hwdata[A_DBL_POS];
      if (w_b) begin
        ninth <= hwdata[B_NINTH_POS];
        size2 <= hwdata[B_SIZE2_POS];
        tx_enable_bit  <= hwdata[B_TX_ENABLE_BIT_POS];
        master <= hwdata[8];   // clock pin direction
      end
      if (w_c_sel) ctrl_c <= {1'b0, hwdata[6:0]};
      else if (w_c) baud[11:8] <= hwdata[3:0];
      if (w_baud_lo) baud[7:0] <= hwdata[7:0];
    end
  end

  // read mux, registered data
  logic [31:0] rd_mux;
  assign rd_mux =
    (haddr == OFF_STAT_A) ? {24'h0, rx_complete_flag, tx_complete_flag, empty, fe, 2'b00, dbl, 1'b0} :
    (haddr == OFF_CTRL_B) ? {23'h0, master, 3'b000, 1'b0, tx_enable_bit, size2, 1'b0, ninth} :
    (haddr == OFF_CTRL_C) ? {24'h0, 1'b1, ctrl_c[6:0]} :
    (haddr == OFF_BAUD_LO) ? {24'h0, baud[7:0]} : 32'h0000_0000;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_valid && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

  // checks
  a_start_low: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_START) |-> !txd_out)
    else $error("start bit not low");
  a_stop_high: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_STOP1 || state == ST_STOP2 || state == ST_IDLE) |-> txd_out)
    else $error("stop or idle not high");
  a_load_empties: assert property (@(posedge hclk) disable iff (!hresetn)
    (load && !w_data) |=> empty && state == ST_START)
    else $error("load did not empty buffer");
  a_write_fills: assert property (@(posedge hclk) disable iff (!hresetn)
    w_data |=> !empty)
    else $error("write left buffer empty");
  a_txc_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    (frame_end && empty && !w_data) |=> tx_complete_flag)
    else $error("complete flag not set");
  a_pin_held: assert property (@(posedge hclk) disable iff (!hresetn)
    (!tx_enable_bit && state != ST_IDLE) |=> txd_oe)
    else $error("pin released mid frame");
  a_data_count: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_DATA) |-> bit_cnt < nbits)
    else $error("too many data bits");
  a_parity_order: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_PARITY && shift_en) |=> state == ST_STOP1)
    else $error("parity not before stop");
  a_parity_val: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_PARITY) |-> txd_out == par_bit)
    else $error("parity bit wrong");
  a_ctrl_select: assert property (@(posedge hclk) disable iff (!hresetn)
    (w_c && !hwdata[C_SEL_POS]) |=> $stable(ctrl_c))
    else $error("control C written without select");
  c_back_to_back: cover property (@(posedge hclk) disable iff (!hresetn)
    frame_end && load);
  c_two_stop: cover property (@(posedge hclk) disable iff (!hresetn)
    state == ST_STOP2);
  c_parity: cover property (@(posedge hclk) disable iff (!hresetn)
    state == ST_PARITY);

endmodule

//--- serial_partner.sv
`timescale 1ns/100ps
// remote receiver on the serial line, and clock source for sync slave mode
module serial_partner (
  // system
  input  wire logic        hclk,
  // line side
  input  wire logic        txd,
  input  wire logic        transfer_clock_pin,
  output logic             xck_drv,
  // setup from the bench
  input  wire logic        sync_mode,
  input  wire logic        pol,
  input  wire logic        run,
  input  wire logic [3:0]  nbits,
  input  wire logic [7:0]  bitc,
  // captured frame
  output logic [12:0]      frame,
  output logic             done
);
  // link clock, unrelated phase, still while run is low
  initial begin
    xck_drv = 1'b0;
    #7;
    forever #160 if (run) xck_drv = ~xck_drv;
  end

  // sample on the edge opposite to the change edge
  task automatic samp_edge();
    if (pol) @(posedge transfer_clock_pin);
    else @(negedge transfer_clock_pin);
  endtask

  // capture one frame per start edge
  initial begin
    done = 1'b0;
    forever begin
      frame = '1;
      @(negedge txd);
      if (!sync_mode) begin
        // async: bit centres, half a bit after the start edge
        repeat (bitc / 2) @(posedge hclk);
        for (int i = 0; i < nbits; i++) begin
          frame[i] = txd;
          if (i < nbits - 1) repeat (bitc) @(posedge hclk);
        end
      end else begin
        // sync: one bit per sampling edge
        for (int i = 0; i < nbits; i++) begin
          samp_edge();
          frame[i] = txd;
        end
      end
      @(posedge hclk);
      done <= 1'b1;
      @(posedge hclk);
      done <= 1'b0;
    end
  end
endmodule

//--- testbench.sv
`timescale 1ns/100ps
module testbench;
  import frame_tx_pkg::*;
  // bus and pins
  logic        hclk, hresetn, hsel, hwrite, hready, hresp;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rq;
  logic        txd_out, txd_oe, xck_out, xck_oe, xck_drv;
  logic        rx_stop1, rx_stop_valid, rx_done;
  // partner setup and results
  logic        sync_mode, pol, run, done;
  logic [3:0]  nbits;
  logic [7:0]  bitc;
  logic [12:0] frame;
  int          num_errors, cmp_count, cycles;
  time         t1, t2;
  // rows: stop2, parity, size code, nine data bits
  logic [14:0] rows [5] = '{15'h06A5, 15'h60F6, 15'h32D3, 15'h24FF, 15'h7FC5};
  // released data pin sits at its pull-up level; released clock pin follows xck_drv
  wire         txd_pin = txd_oe ? txd_out : 1'b1;
  wire         xck_pin = xck_oe ? xck_out : xck_drv;

  frame_tx_core u_frame_tx_core (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .txd_out(txd_out),
    .txd_oe(txd_oe), .xck_in(xck_pin), .xck_out(xck_out), .xck_oe(xck_oe),
    .rx_stop1(rx_stop1), .rx_stop_valid(rx_stop_valid), .rx_done(rx_done));

  serial_partner u_serial_partner (
    .hclk(hclk), .txd(txd_pin), .transfer_clock_pin(xck_pin), .xck_drv(xck_drv),
    .sync_mode(sync_mode), .pol(pol), .run(run), .nbits(nbits), .bitc(bitc),
    .frame(frame), .done(done));

  // 25 MHz system clock
  always #20 hclk = ~hclk;

  // hang guard, far above the expected run length
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      close_out();
    end
  end

  // verdict and end of run
  task automatic close_out();
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // compare a word
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // compare a single pin
  task automatic check_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one single transfer: address phase, then data phase
  task automatic ahb(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= is_wr;
    htrans <= 2'b10;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rq = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    check_word(rq, exp);
  endtask

  // poll status A until a flag is set
  task automatic wait_a(input int b);
    ahb(1'b0, OFF_STAT_A, 32'h0);
    while (rq[b] !== 1'b1) ahb(1'b0, OFF_STAT_A, 32'h0);
  endtask

  task automatic wait_done();
    @(posedge hclk);
    while (done !== 1'b1) @(posedge hclk);
  endtask

  // expected line bits of one frame, unused slots high
  function automatic logic [12:0] exp_frame(input logic [14:0] r, output logic [3:0] len);
    logic [12:0] f;
    logic        p;
    int          n;
    int          k;
    f = '1;
    f[0] = 1'b0;
    p = r[12];
    n = (r[11:9] == SIZE_NINE) ? 9 : int'(r[11:9]) + 5;
    for (int i = 0; i < n; i++) begin
      f[1 + i] = r[i];
      p = p ^ r[i];
    end
    k = 1 + n;
    if (r[13]) begin
      f[k] = p;
      k++;
    end
    len = 4'(k + 1 + int'(r[14]));
    return f;
  endfunction

  // set format, send one character, check it and the flags after it
  task automatic send(input logic [14:0] r, input logic sy, input logic ms, input logic pl);
    logic [12:0] ef;
    logic [3:0]  len;
    ef = exp_frame(r, len);
    wr(OFF_CTRL_C, {24'h0, 1'b1, sy, r[13:12], r[14], r[10:9], pl});
    wr(OFF_CTRL_C, 32'h70);
    wr(OFF_CTRL_B, {23'h0, ms, 4'h0, 1'b1, r[11], 1'b0, r[8]});
    sync_mode <= sy;
    pol <= pl;
    nbits <= len;
    bitc <= 8'h10;
    wr(OFF_DATA, {23'h0, r[8:0]});
    run <= sy & ~ms;
    wait_done();
    check_word({19'h0, frame}, {19'h0, ef});
    check_bit(xck_oe, sy & ms);
    check_bit(txd_oe, 1'b1);
    wait_a(A_TXC_POS);
    run <= 1'b0;
    check_word(rq, 32'h60);
    check_bit(txd_out, 1'b1);
    wr(OFF_STAT_A, 32'h40);
    rd_chk(OFF_STAT_A, 32'h20);
  endtask

  // main sequence
  initial begin
    logic [12:0] ef;
    logic [3:0]  len;
    {hclk, hresetn, hsel, hwrite, run, sync_mode, pol} = '0;
    {rx_stop1, rx_stop_valid, rx_done} = '0;
    {haddr, htrans, hwdata, cycles, num_errors, cmp_count} = '0;
    hsize = 3'h2;
    nbits = 4'hA;
    bitc = 8'h10;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    check_bit(txd_pin, 1'b1);
    rd_chk(OFF_STAT_A, 32'h20);
    rd_chk(8'h14, 32'h0);
    check_bit(hresp, 1'b0);
    wr(OFF_BAUD_LO, 32'h0);
    // every size, parity mode and stop count, async
    for (int i = 0; i < 5; i++) send(rows[i], 1'b0, 1'b0, 1'b0);
    // sync slave and master, both polarities, then one async frame again
    send(rows[0], 1'b1, 1'b0, 1'b0);
    send(rows[4], 1'b1, 1'b0, 1'b1);
    send(rows[1], 1'b1, 1'b1, 1'b0);
    send(rows[2], 1'b1, 1'b1, 1'b1);
    send(rows[0], 1'b0, 1'b0, 1'b0);
    // double speed: eight clocks a bit
    wr(OFF_STAT_A, 32'h02);
    bitc <= 8'h08;
    wr(OFF_DATA, 32'h3C);
    wait_done();
    ef = exp_frame(15'h063C, len);
    check_word({19'h0, frame}, {19'h0, ef});
    wait_a(A_TXC_POS);
    wr(OFF_STAT_A, 32'h40);
    bitc <= 8'h10;
    // back-to-back: second char waits in the buffer, no gap on the line
    wr(OFF_DATA, 32'hA5);
    wait_a(A_EMPTY_POS);
    wr(OFF_DATA, 32'h3C);
    wait_done();
    t1 = $time;
    wait_done();
    t2 = $time;
    check_word(32'(t2 - t1), 32'd6400);
    ef = exp_frame(15'h063C, len);
    check_word({19'h0, frame}, {19'h0, ef});
    wait_a(A_TXC_POS);
    // disable with a character still waiting in the buffer: pin kept until the frame is out
    wr(OFF_STAT_A, 32'h40);
    wr(OFF_DATA, 32'h5A);
    wr(OFF_CTRL_B, 32'h0);
    check_bit(txd_oe, 1'b1);
    wait_done();
    ef = exp_frame(15'h065A, len);
    check_word({19'h0, frame}, {19'h0, ef});
    wait_a(A_TXC_POS);
    repeat (2) @(posedge hclk);
    check_bit(txd_oe, 1'b0);
    // receiver hooks: first stop low flags frame error
    rx_stop_valid <= 1'b1;
    rx_done <= 1'b1;
    @(posedge hclk);
    rx_stop_valid <= 1'b0;
    rx_done <= 1'b0;
    rd_chk(OFF_STAT_A, 32'hF0);
    wr(OFF_STAT_A, 32'hC0);
    rx_stop1 <= 1'b1;
    rx_stop_valid <= 1'b1;
    @(posedge hclk);
    rx_stop_valid <= 1'b0;
    rd_chk(OFF_STAT_A, 32'h20);
    close_out();
  end
endmodule
